// ---- logic/dmr_router.sv ----
// Data memory access router: on-chip xdata SRAM, external bus, scratchpad
// What this block does
// [R1] 1 KB on-chip SRAM at 0000-03FF, data only
// [R2] Enabled SRAM takes low 1 KB data moves
// [R3] Reset clears enable; all data goes external
// [R4] Enabled: addresses above 03FF go external
// [R5] Disabled: whole 64K data space goes external
// [R6] Port 0 push-pull bus during external access
// [R7] Port 2 drives high address while bus
// [R8] Scratchpad separate from on-chip data SRAM
// [R9] Scratchpad direct/indirect; registers direct only
// [R10] Code fetch and code moves use code space
// [R11] Up to 64K external data via moves
// [R12] Wait enable makes wait pin input only
// [R13] Scratchpad banks, bit area, direct, indirect
// [R14] On-chip access: no strobes, no bus
`include "dmr_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dmr_router (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire dmr_pkg::dmr_space_t reqSpace,
  input wire logic reqWrite,
  input wire logic [15:0] reqAddr,
  input wire logic [7:0] reqWData,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWData,
  input wire logic waitEnable,
  input wire logic [7:0] port0Gpio,
  input wire logic [7:0] port2Gpio,
  input wire logic [7:0] port0In,
  input wire logic waitPinIn,
  input wire logic waitPinGpio,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic busy,
  output logic scratchSel,
  output logic sfrSel,
  output logic [7:0] scratchAddr,
  output logic [1:0] scratchRegion,
  output logic onchipSramEnable,
  output logic [7:0] port0Out,
  output logic [7:0] port0Oe,
  output logic [7:0] port2Out,
  output logic [7:0] port2Oe,
  output logic ale,
  output logic rdStrobe_n,
  output logic wrStrobe_n,
  output logic psen_n,
  output logic waitPinOut,
  output logic waitPinOe
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] sram [0:`DMR_SRAM_WORDS-1]; // On-chip data SRAM
  logic pmrEn_ff; // SRAM enable bit of power management register
  logic [2:0] waitSync_ff; // Wait pin synchroniser
  logic waitReq_ff; // Filtered wait request
  logic [7:0] rdData_ff;
  logic rdValid_ff;
  logic scratchSel_ff;
  logic sfrSel_ff;
  logic [7:0] scratchAddr_ff;
  logic [1:0] scratchRegion_ff;
  logic [7:0] p0Out_ff;
  logic [7:0] p0Oe_ff;
  logic [7:0] p2Out_ff;
  logic [7:0] p2Oe_ff;
  logic ale_ff;
  logic rd_n_ff;
  logic wr_n_ff;
  logic psen_n_ff;
  logic wpOut_ff;
  logic wpOe_ff;
  logic [2:0] extCnt_ff; // Phase counter of an external cycle
  logic busy_ff; // Registered busy, high while the counter is non-zero
  logic extWrite_ff; // Current external cycle is a write
  logic extCode_ff; // Current external cycle is a code read
  logic [15:0] extAddr_ff;
  logic [7:0] extData_ff;
  logic isXdata;
  logic isCode;
  logic hitSram;
  logic goExt;
  logic extActive;
  logic extLast;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  // Data moves only; code requests never reach the SRAM
  assign isXdata = reqValid && (reqSpace == dmr_pkg::SpXdata); // [R11]
  assign isCode = reqValid && (reqSpace == dmr_pkg::SpCode); // [R10]
  assign hitSram = isXdata && pmrEn_ff && (reqAddr <= `DMR_SRAM_LAST); // [R1] [R2]
  // Above the window, or whole space when disabled, goes out
  assign goExt = ((isXdata && !hitSram) || isCode) && !extActive; // [R4] [R5]
  assign extActive = (extCnt_ff != 3'h0);
  // Last phase is held while the wait pin asks for more time
  assign extLast = (extCnt_ff == 3'(`DMR_EXT_CYCLES)) && !(waitEnable && waitReq_ff);

  // ----------------------------------------
  // Power management register
  // ----------------------------------------
  // Reset leaves the SRAM off, so everything is external
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pmrEn_ff <= 1'b0; // [R3]
    end else if (sfrWrite && sfrAddr == `DMR_PMR_SFR_ADDR) begin
      pmrEn_ff <= sfrWData[`DMR_PMR_SRAM_EN_BIT];
    end
  end

  // ----------------------------------------
  // On-chip SRAM
  // ----------------------------------------
  // No reset on the array; contents are undefined after power up
  always_ff @(posedge clock) begin
    if (hitSram && reqWrite) begin
      sram[reqAddr[`DMR_SRAM_AW-1:0]] <= reqWData; // [R1]
    end
  end

  // ----------------------------------------
  // Read data return
  // ----------------------------------------
  // SRAM answers next cycle; external at end of the bus cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= 8'h00;
      rdValid_ff <= 1'b0;
    end else if (hitSram && !reqWrite) begin
      rdData_ff <= sram[reqAddr[`DMR_SRAM_AW-1:0]]; // [R2]
      rdValid_ff <= 1'b1;
    end else if (extActive && extLast && !extWrite_ff) begin
      rdData_ff <= port0In;
      rdValid_ff <= 1'b1;
    end else begin
      rdValid_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Scratchpad and register select
  // ----------------------------------------
  // Indirect access above 7F is RAM, direct access there is a register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scratchSel_ff <= 1'b0;
      sfrSel_ff <= 1'b0;
      scratchAddr_ff <= 8'h00;
      scratchRegion_ff <= 2'h0;
    end else begin
      scratchAddr_ff <= reqAddr[7:0]; // [R8]
      scratchSel_ff <= 1'b0;
      sfrSel_ff <= 1'b0;
      if (reqValid && reqSpace == dmr_pkg::SpScratchInd) begin
        scratchSel_ff <= 1'b1; // [R9]
      end else if (reqValid && reqSpace == dmr_pkg::SpScratchDir) begin
        scratchSel_ff <= (reqAddr[7:0] <= `DMR_DIRECT_LAST); // [R9]
        sfrSel_ff <= (reqAddr[7:0] > `DMR_DIRECT_LAST); // [R9]
      end
      // Region classification
      if (reqAddr[7:0] <= `DMR_BANK_LAST) begin
        scratchRegion_ff <= dmr_pkg::RgBank; // [R13]
      end else if (reqAddr[7:0] <= `DMR_BITRAM_LAST) begin
        scratchRegion_ff <= dmr_pkg::RgBit; // [R13]
      end else if (reqAddr[7:0] <= `DMR_DIRECT_LAST) begin
        scratchRegion_ff <= dmr_pkg::RgDirect; // [R13]
      end else begin
        scratchRegion_ff <= dmr_pkg::RgIndirect; // [R13]
      end
    end
  end

  // ----------------------------------------
  // External cycle sequencer
  // ----------------------------------------
  // Phase 1 address with ALE, then strobe phases until the last
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      extCnt_ff <= 3'h0;
      busy_ff <= 1'b0;
      extWrite_ff <= 1'b0;
      extCode_ff <= 1'b0;
      extAddr_ff <= 16'h0000;
      extData_ff <= 8'h00;
    end else if (goExt) begin
      extCnt_ff <= 3'h1;
      busy_ff <= 1'b1;
      extWrite_ff <= reqWrite && isXdata;
      extCode_ff <= isCode;
      extAddr_ff <= reqAddr;
      extData_ff <= reqWData;
    end else if (extActive) begin
      if (extLast) begin
        extCnt_ff <= 3'h0;
        busy_ff <= 1'b0;
      end else if (extCnt_ff != 3'(`DMR_EXT_CYCLES)) begin
        extCnt_ff <= extCnt_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Port 0 / port 2 drivers and strobes
  // ----------------------------------------
  // On-chip hits never start the sequencer, so pins stay idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      p0Out_ff <= 8'h00;
      p0Oe_ff <= 8'h00;
      p2Out_ff <= 8'h00;
      p2Oe_ff <= 8'h00;
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      psen_n_ff <= 1'b1;
    end else if (goExt) begin
      p0Out_ff <= reqAddr[7:0]; // [R6]
      p0Oe_ff <= 8'hff; // [R6]
      p2Out_ff <= reqAddr[15:8]; // [R7]
      p2Oe_ff <= 8'hff; // [R7]
      ale_ff <= 1'b1;
      rd_n_ff <= 1'b1;
      wr_n_ff <= 1'b1;
      psen_n_ff <= 1'b1;
    end else if (extActive && !extLast) begin
      ale_ff <= 1'b0;
      p2Out_ff <= extAddr_ff[15:8]; // [R7]
      p2Oe_ff <= 8'hff; // [R7]
      p0Out_ff <= extData_ff;
      p0Oe_ff <= {8{extWrite_ff}}; // [R6]
      wr_n_ff <= !extWrite_ff;
      rd_n_ff <= extWrite_ff || extCode_ff;
      psen_n_ff <= !extCode_ff;
    end else begin
      // Idle: port 0 open drain, only low bits pull down
      p0Out_ff <= 8'h00; // [R6]
      p0Oe_ff <= ~port0Gpio; // [R6]
      p2Out_ff <= port2Gpio;
      p2Oe_ff <= 8'hff;
      ale_ff <= 1'b0;
      rd_n_ff <= 1'b1; // [R14]
      wr_n_ff <= 1'b1; // [R14]
      psen_n_ff <= 1'b1;
    end
  end

  // ----------------------------------------
  // Wait pin
  // ----------------------------------------
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitSync_ff <= 3'h0;
      waitReq_ff <= 1'b0;
    end else begin
      waitSync_ff <= {waitSync_ff[1:0], waitPinIn};
      if (waitSync_ff[1] == waitSync_ff[2]) begin
        waitReq_ff <= waitSync_ff[2];
      end
    end
  end

  // Enabled wait function turns the pin into an input
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wpOut_ff <= 1'b0;
      wpOe_ff <= 1'b0;
    end else begin
      wpOut_ff <= 1'b0;
      wpOe_ff <= waitEnable ? 1'b0 : !waitPinGpio; // [R12]
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdData = rdData_ff;
  assign rdValid = rdValid_ff;
  assign busy = busy_ff;
  assign scratchSel = scratchSel_ff;
  assign sfrSel = sfrSel_ff;
  assign scratchAddr = scratchAddr_ff;
  assign scratchRegion = scratchRegion_ff;
  assign onchipSramEnable = pmrEn_ff;
  assign port0Out = p0Out_ff;
  assign port0Oe = p0Oe_ff;
  assign port2Out = p2Out_ff;
  assign port2Oe = p2Oe_ff;
  assign ale = ale_ff;
  assign rdStrobe_n = rd_n_ff;
  assign wrStrobe_n = wr_n_ff;
  assign psen_n = psen_n_ff;
  assign waitPinOut = wpOut_ff;
  assign waitPinOe = wpOe_ff;
endmodule : dmr_router
`default_nettype wire

// ---- logic/dmr_defs.svh ----
// Constants for the data memory access router
`ifndef DMR_DEFS_SVH
`define DMR_DEFS_SVH
// ----------------------------------------
// Address map
// ----------------------------------------
`define DMR_SRAM_LAST 16'h03ff
`define DMR_SRAM_AW 10
`define DMR_SRAM_WORDS 1024
`define DMR_BANK_LAST 8'h1f
`define DMR_BITRAM_FIRST 8'h20
`define DMR_BITRAM_LAST 8'h2f
`define DMR_DIRECT_LAST 8'h7f
// ----------------------------------------
// Power management register fields
// ----------------------------------------
`define DMR_PMR_SFR_ADDR 8'hc4
`define DMR_PMR_SRAM_EN_BIT 0
`define DMR_PMR_RESET 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define DMR_CLOCK_MHZ 50
`define DMR_EXT_CYCLES 4
`endif

// ---- logic/dmr_pkg.sv ----
// Types shared by the data memory access router
`timescale 1ns/1ps
`default_nettype none
package dmr_pkg;
  // Which space a request goes to
  typedef enum logic [2:0] {
    SpNone, SpCode, SpXdata, SpScratchDir, SpScratchInd
  } dmr_space_t;
  // Target chosen for a scratchpad region
  typedef enum logic [1:0] {
    RgBank, RgBit, RgDirect, RgIndirect
  } dmr_region_t;
endpackage : dmr_pkg
`default_nettype wire

// ---- dv/dmr_props.sv ----
// Port assertions for the data memory access router
`timescale 1ns/1ps
`default_nettype none
module dmr_props (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire dmr_pkg::dmr_space_t reqSpace,
  input wire logic [15:0] reqAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWData,
  input wire logic waitEnable,
  input wire logic busy,
  input wire logic scratchSel,
  input wire logic sfrSel,
  input wire logic [7:0] scratchAddr,
  input wire logic onchipSramEnable,
  input wire logic [7:0] port0Out,
  input wire logic [7:0] port0Oe,
  input wire logic [7:0] port2Out,
  input wire logic [7:0] port2Oe,
  input wire logic ale,
  input wire logic rdStrobe_n,
  input wire logic psen_n,
  input wire logic waitPinOe
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Enable only follows a write of bit 0 at its address
  en_cause_a: assert property ($rose(onchipSramEnable) |->
    $past(sfrWrite) && $past(sfrAddr) == 8'hc4 && ($past(sfrWData) & 8'h01) != 8'h00)
    else $error("enable set without its write");
  sram_quiet_a: assert property (reqValid && reqSpace == dmr_pkg::SpXdata && !busy &&
    onchipSramEnable && reqAddr <= 16'h03ff |=> !ale && !busy)
    else $error("on-chip access drove the bus");
  ext_route_a: assert property (reqValid && reqSpace == dmr_pkg::SpXdata && !busy &&
    (!onchipSramEnable || reqAddr > 16'h03ff) |=> ale && {port2Out, port0Out} == $past(reqAddr))
    else $error("external access missing address");
  addr_drive_a: assert property (ale |-> port2Oe == 8'hff && port0Oe == 8'hff)
    else $error("address not driven");
  code_ext_a: assert property (reqValid && reqSpace == dmr_pkg::SpCode && !busy |=>
    ale ##1 !psen_n) else $error("code fetch not external");
  rd_release_a: assert property (!rdStrobe_n |-> port0Oe == 8'h00)
    else $error("port 0 driven during read");
  wait_input_a: assert property ($past(waitEnable) && waitEnable |-> !waitPinOe)
    else $error("wait pin driven");
  scr_ind_a: assert property (reqValid && reqSpace == dmr_pkg::SpScratchInd |=>
    scratchSel && !sfrSel && scratchAddr == $past(reqAddr[7:0]))
    else $error("indirect not to scratchpad");
  sfr_dir_a: assert property (reqValid && reqSpace == dmr_pkg::SpScratchDir && reqAddr[7] |=>
    sfrSel && !scratchSel) else $error("direct high not to register");
endmodule : dmr_props
`default_nettype wire

// ---- dv/dmr_ext_mem.sv ----
// External memory model on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module dmr_ext_mem (
  input wire logic clock,
  input wire logic slow,
  input wire logic ale,
  input wire logic rdStrobe_n,
  input wire logic wrStrobe_n,
  input wire logic psen_n,
  input wire logic [7:0] port0Out,
  input wire logic [7:0] port2Out,
  output logic [7:0] port0In,
  output logic waitPinIn
);
  // ----------
  // Memory
  // ----------
  logic [7:0] mem [0:65535]; // Code and data share it
  logic [15:0] addrFf; // Latched address
  logic [7:0] lastFf = 8'h00; // Last bus value
  int strbCnt = 0; // Cycles with a strobe low
  // Latch address, take writes, count strobe length
  always @(posedge clock) begin
    if (ale) addrFf <= {port2Out, port0Out};
    if (!wrStrobe_n) mem[addrFf] <= port0Out;
    strbCnt <= (rdStrobe_n && wrStrobe_n && psen_n) ? 0 : strbCnt + 1;
    lastFf <= port0In;
  end
  // Released bus toggles, so no stale byte can pass
  assign port0In = (rdStrobe_n && psen_n) ? ~lastFf : mem[addrFf];
  // Slow mode asks for two wait cycles per strobe
  assign waitPinIn = slow && strbCnt < 2 && !(rdStrobe_n && wrStrobe_n && psen_n);
endmodule : dmr_ext_mem
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the data memory access router
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------
  // Signals
  // ----------
  logic clock, rst_n, reqValid, reqWrite, sfrWrite, waitEnable, slow, bus, enRef;
  logic rdValid, busy, scratchSel, sfrSel, ale, rdStrobe_n, wrStrobe_n, psen_n;
  logic onchipSramEnable, waitPinIn, waitPinOut, waitPinOe;
  logic waitPinGpio = 1'b0; // Tied
  logic [7:0] port0Gpio = 8'h5a; // Tied
  logic [7:0] port2Gpio = 8'ha5; // Tied
  dmr_pkg::dmr_space_t reqSpace;
  logic [15:0] reqAddr, a;
  logic [7:0] reqWData, sfrAddr, sfrWData, port0In, rdData, got, scratchAddr;
  logic [7:0] port0Out, port0Oe, port2Out, port2Oe;
  logic [1:0] scratchRegion;
  logic [15:0] tbl [4] = '{16'h0000, 16'h03ff, 16'h0400, 16'hffff}; // Edges
  logic [7:0] sa [5] = '{8'h08, 8'h2a, 8'h55, 8'h90, 8'h90}; // Scratch cases
  logic [7:0] extRef [int]; // Far side contents
  logic [7:0] ramRef [int]; // On-chip contents
  int bad_count, tests_run, seed, i;
  dmr_router uut (.*);
  dmr_ext_mem partner (.*);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ----------
  // Helpers
  // ----------
  function automatic int nxt(input int s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  // One request, then follow it until idle
  task automatic req(input dmr_pkg::dmr_space_t sp, input logic wr, input logic [15:0] ad,
                     input logic [7:0] d);
    int n;
    @(posedge clock);
    #1;
    reqValid = 1'b1;
    reqSpace = sp;
    reqWrite = wr;
    reqAddr = ad;
    reqWData = d;
    @(posedge clock);
    #1;
    reqValid = 1'b0;
    bus = 1'b0;
    got = 8'h00;
    n = 0;
    forever begin
      bus |= ale | !rdStrobe_n | !wrStrobe_n | !psen_n;
      if (rdValid) got = rdData;
      if (!busy) break;
      if (++n > 40) begin
        chk("timeout", 16'h0001, 16'h0000);
        close_out();
      end
      @(posedge clock);
      #1;
    end
  endtask : req
  // Data move against the reference map
  task automatic xd(input logic wr, input logic [15:0] ad, input logic [7:0] d);
    bit loc;
    loc = enRef && ad <= 16'h03ff;
    req(dmr_pkg::SpXdata, wr, ad, d);
    chk("bus_used", bus, !loc);
    if (wr && loc) ramRef[ad] = d;
    else if (wr) extRef[ad] = d;
    else chk("rd_data", got, loc ? ramRef[ad] : extRef[ad]);
  endtask : xd
  // ----------
  // Sequence
  // ----------
  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqSpace = dmr_pkg::SpNone;
    reqAddr = 16'h0000;
    reqWData = 8'h00;
    sfrWrite = 1'b0;
    sfrAddr = 8'h00;
    sfrWData = 8'h00;
    waitEnable = 1'b0;
    slow = 1'b0;
    enRef = 1'b0;
    bad_count = 0;
    tests_run = 0;
    seed = 91851;
    repeat (10) @(posedge clock);
    #1;
    rst_n = 1'b1;
    @(posedge clock);
    #1;
    chk("en_reset", onchipSramEnable, 1'b0);
    chk("p0oe_idle", port0Oe, 8'ha5);
    chk("p2oe_idle", port2Oe, 8'hff);
    $display("reset test done");
    // Phase 0 disabled, phase 1 enabled with waits
    for (int ph = 0; ph < 2; ph++) begin
      waitEnable = ph[0];
      slow = ph[0];
      for (int k = 0; k < 2; k++) begin
        @(posedge clock);
        #1;
        sfrWrite = 1'b1;
        sfrAddr = k ? 8'hc4 : 8'hc5;
        sfrWData = ph[0] ? 8'h01 : 8'hfe;
        @(posedge clock);
        #1;
        sfrWrite = 1'b0;
      end
      enRef = ph[0];
      chk("sram_en", onchipSramEnable, enRef);
      chk("wait_oe", waitPinOe, !ph[0]);
      chk("wait_out", waitPinOut, 1'b0);
      for (i = 0; i < 6; i++) begin
        seed = nxt(seed);
        a = (i < 4) ? tbl[i] : (i == 4) ? {6'h00, seed[9:0]} : seed[15:0];
        xd(1'b1, a, seed[23:16]);
        xd(1'b0, a, 8'h00);
      end
      $display("phase %0d test done", ph);
    end
    req(dmr_pkg::SpCode, 1'b0, 16'h0000, 8'h00);
    chk("code_bus", bus, 1'b1);
    chk("code_data", got, extRef[0]);
    for (i = 0; i < 5; i++) begin
      req(i == 4 ? dmr_pkg::SpScratchInd : dmr_pkg::SpScratchDir, 1'b0, sa[i], 8'h00);
      chk("sfr_sel", sfrSel, i == 3);
      chk("scr_sel", scratchSel, i != 3);
      if (i != 3) chk("region", scratchRegion, i == 4 ? 3 : i);
    end
    $display("scratch test done");
    close_out();
  end
endmodule : tb_top
bind dmr_router dmr_props u_props (.*);
`default_nettype wire
